// ---- src/gltc_config.sv ----
`timescale 1ns/10ps
`include "gltc_map.svh"
// Behaviour
// - data-one length 1.50/1.66/1.83/2.00 Tari, reset 11
// - tari code 000/001/010 selects 6.25/12.5/25us
// - link frequency codes for 40 to 640 kHz
// - preamble bit long when set; short needs Miller4/8
// - receive coding FM0, Miller 2, 4, 8
// - cal period upper nibble high, low byte
// - cal period counts 0.1us steps, 4096 codes
// - top three high bits are analog adaptations
// - ack wait 3.2us steps, reset 4
// - reply timeout 25.6us steps, reset 15
// - timeout code 255 means 26.2 ms
// - interrupt when timeout beats tag preamble
// - timer starts when transmit ends with a nonzero timeout code
// - auto acknowledge mode none/auto/auto plus handle
module gltc_config #(
  parameter int STEP_CYC = `GLTC_TIMEOUT_STEP_CYC,
  parameter int EXT_CYC  = `GLTC_TIMEOUT_EXT_CYC
) (
  input  wire logic             clock_i,
  input  wire logic             arst_n_i,
  input  wire gltc_pkg::gltc_req_t req_i,
  input  wire logic [1:0]       auto_acknowledge_mode_i,
  input  wire logic             tx_done_i,
  input  wire logic             preamble_seen_i,
  output logic [7:0]            rdata_o,
  output logic                  rvalid_o,
  output gltc_pkg::gltc_cfg_t   cfg_o,
  output logic                  short_preamble_bad_o,
  output logic                  reply_timer_running_o,
  output logic                  no_reply_irq_o
);
  logic [7:0] tx_opt_reg, rx_opt_reg, cal_hi_reg, cal_lo_reg, ack_reg, tmo_reg;
  logic [7:0] rdata_reg, rdata_next;
  logic       rvalid_reg;
  logic [1:0] ack_mode_reg;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
    return a == b;
  endfunction

  wire wr_tx  = req_i.we && hit(req_i.addr, `GLTC_ADDR_TX_SYMBOL_OPTIONS);
  wire wr_rx  = req_i.we && hit(req_i.addr, `GLTC_ADDR_RX_LINK_OPTIONS);
  wire wr_chi = req_i.we && hit(req_i.addr, `GLTC_ADDR_CAL_PERIOD_HIGH);
  wire wr_clo = req_i.we && hit(req_i.addr, `GLTC_ADDR_CAL_PERIOD_LOW);
  wire wr_ack = req_i.we && hit(req_i.addr, `GLTC_ADDR_ACK_WAIT_TIME);
  wire wr_tmo = req_i.we && hit(req_i.addr, `GLTC_ADDR_REPLY_TIMEOUT);

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_opt_reg   <= `GLTC_RST_TX_SYMBOL_OPTIONS;
      rx_opt_reg   <= `GLTC_RST_RX_LINK_OPTIONS;
      cal_hi_reg   <= `GLTC_RST_CAL_PERIOD_HIGH;
      cal_lo_reg   <= `GLTC_RST_CAL_PERIOD_LOW;
      ack_reg      <= `GLTC_RST_ACK_WAIT_TIME;
      tmo_reg      <= `GLTC_RST_REPLY_TIMEOUT;
      ack_mode_reg <= `GLTC_RST_AUTO_ACK_MODE;
    end else begin
      if (wr_tx)
        tx_opt_reg <= req_i.wdata & `GLTC_MASK_TX_SYMBOL_OPTIONS;
      if (wr_rx)
        rx_opt_reg <= req_i.wdata;
      if (wr_chi)
        cal_hi_reg <= req_i.wdata & `GLTC_MASK_CAL_PERIOD_HIGH;
      if (wr_clo)
        cal_lo_reg <= req_i.wdata;
      if (wr_ack)
        ack_reg <= req_i.wdata;
      if (wr_tmo)
        tmo_reg <= req_i.wdata;
      if (auto_acknowledge_mode_i != 2'b11)
        ack_mode_reg <= auto_acknowledge_mode_i;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    unique case (req_i.addr)
      `GLTC_ADDR_TX_SYMBOL_OPTIONS: rdata_next = tx_opt_reg;
      `GLTC_ADDR_RX_LINK_OPTIONS:   rdata_next = rx_opt_reg;
      `GLTC_ADDR_CAL_PERIOD_HIGH:   rdata_next = cal_hi_reg;
      `GLTC_ADDR_CAL_PERIOD_LOW:    rdata_next = cal_lo_reg;
      `GLTC_ADDR_ACK_WAIT_TIME:     rdata_next = ack_reg;
      `GLTC_ADDR_REPLY_TIMEOUT:     rdata_next = tmo_reg;
      default:                      rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= req_i.re;
      if (req_i.re)
        rdata_reg <= rdata_next;
    end
  end
  assign rdata_o  = rdata_reg;
  assign rvalid_o = rvalid_reg;

  assign cfg_o.data_one_len_sel            = tx_opt_reg[5:4];
  assign cfg_o.tari_sel                    = tx_opt_reg[2:0];
  assign cfg_o.link_freq_sel               = rx_opt_reg[7:4];
  assign cfg_o.preamble_long               = rx_opt_reg[3];
  assign cfg_o.rx_coding_sel               = rx_opt_reg[2:0];
  assign cfg_o.lo_shifter_low_supply       = cal_hi_reg[7];
  assign cfg_o.refl_indicator_gain_double  = cal_hi_reg[6];
  assign cfg_o.refl_indicator_gain_onehalf = cal_hi_reg[5];
  assign cfg_o.cal_period                  = {cal_hi_reg[3:0], cal_lo_reg};
  assign cfg_o.ack_wait_count              = ack_reg;
  assign cfg_o.reply_timeout_count         = tmo_reg;
  assign cfg_o.auto_acknowledge_mode       = ack_mode_reg;

  // flags a short preamble paired with FM0 or Miller 2
  assign short_preamble_bad_o = !rx_opt_reg[3] &&
                                (rx_opt_reg[2:0] == 3'b000 || rx_opt_reg[2:0] == 3'b001);

  gltc_reply_timer #(
    .STEP_CYC(STEP_CYC),
    .EXT_CYC (EXT_CYC)
  ) u_timer (
    .clock_i        (clock_i),
    .arst_n_i       (arst_n_i),
    .timeout_code_i (tmo_reg),
    .tx_done_i      (tx_done_i),
    .preamble_seen_i(preamble_seen_i),
    .running_o      (reply_timer_running_o),
    .expired_o      (no_reply_irq_o)
  );
endmodule

// ---- src/gltc_map.svh ----
`ifndef GLTC_MAP_SVH
`define GLTC_MAP_SVH
// register addresses
`define GLTC_ADDR_TX_SYMBOL_OPTIONS 6'h02
`define GLTC_ADDR_RX_LINK_OPTIONS   6'h03
`define GLTC_ADDR_CAL_PERIOD_HIGH   6'h04
`define GLTC_ADDR_CAL_PERIOD_LOW    6'h05
`define GLTC_ADDR_ACK_WAIT_TIME     6'h06
`define GLTC_ADDR_REPLY_TIMEOUT     6'h07
// reset values
`define GLTC_RST_TX_SYMBOL_OPTIONS  8'h32
`define GLTC_RST_RX_LINK_OPTIONS    8'hca
`define GLTC_RST_CAL_PERIOD_HIGH    8'h02
`define GLTC_RST_CAL_PERIOD_LOW     8'h9b
`define GLTC_RST_ACK_WAIT_TIME      8'h04
`define GLTC_RST_REPLY_TIMEOUT      8'h0f
`define GLTC_RST_AUTO_ACK_MODE      2'h0
// writable bit masks, reserved bits read zero
`define GLTC_MASK_TX_SYMBOL_OPTIONS 8'h37
`define GLTC_MASK_CAL_PERIOD_HIGH   8'hef
`define GLTC_MASK_PLACEHOLDER       8'h00
// field positions
`define GLTC_POS_DATA_ONE           4
`define GLTC_POS_LINK_FREQ          4
`define GLTC_POS_PREAMBLE_LONG      3
`define GLTC_POS_LO_SHIFTER         7
`define GLTC_POS_GAIN_DOUBLE        6
`define GLTC_POS_GAIN_ONEHALF       5
// timing, clock at 20 MHz (50 ns)
`define GLTC_CLK_PERIOD_NS          50
`define GLTC_TIMEOUT_STEP_NS        25600
`define GLTC_TIMEOUT_STEP_CYC       (`GLTC_TIMEOUT_STEP_NS / `GLTC_CLK_PERIOD_NS)
`define GLTC_TIMEOUT_EXT_NS         26200000
`define GLTC_TIMEOUT_EXT_CYC        (`GLTC_TIMEOUT_EXT_NS / `GLTC_CLK_PERIOD_NS)
`define GLTC_ACK_STEP_NS            3200
`define GLTC_ACK_STEP_CYC           (`GLTC_ACK_STEP_NS / `GLTC_CLK_PERIOD_NS)
`define GLTC_TIMEOUT_EXT_CODE       8'hff
`endif

// ---- src/gltc_pkg.sv ----
package gltc_pkg;
  typedef enum logic [2:0] {
    GLTC_TARI_6US25 = 3'b000,
    GLTC_TARI_12US5 = 3'b001,
    GLTC_TARI_25US  = 3'b010
  } gltc_tari_t;
  typedef enum logic [2:0] {
    GLTC_COD_FM0 = 3'b000,
    GLTC_COD_M2  = 3'b001,
    GLTC_COD_M4  = 3'b010,
    GLTC_COD_M8  = 3'b011
  } gltc_coding_t;
  typedef enum logic [1:0] {
    GLTC_ACK_NONE  = 2'b00,
    GLTC_ACK_AUTO  = 2'b01,
    GLTC_ACK_REQRN = 2'b10
  } gltc_ack_mode_t;
  typedef struct packed {
    logic [1:0]  data_one_len_sel;
    logic [2:0]  tari_sel;
    logic [3:0]  link_freq_sel;
    logic        preamble_long;
    logic [2:0]  rx_coding_sel;
    logic        lo_shifter_low_supply;
    logic        refl_indicator_gain_double;
    logic        refl_indicator_gain_onehalf;
    logic [11:0] cal_period;
    logic [7:0]  ack_wait_count;
    logic [7:0]  reply_timeout_count;
    logic [1:0]  auto_acknowledge_mode;
  } gltc_cfg_t;
  typedef struct packed {
    logic       we;
    logic       re;
    logic [5:0] addr;
    logic [7:0] wdata;
  } gltc_req_t;
endpackage

// ---- src/gltc_reply_timer.sv ----
`timescale 1ns/10ps
`include "gltc_map.svh"
module gltc_reply_timer #(
  parameter int STEP_CYC = `GLTC_TIMEOUT_STEP_CYC,
  parameter int EXT_CYC  = `GLTC_TIMEOUT_EXT_CYC
) (
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  input  wire logic [7:0] timeout_code_i,
  input  wire logic       tx_done_i,
  input  wire logic       preamble_seen_i,
  output logic            running_o,
  output logic            expired_o
);
  typedef enum logic [1:0] {
    GLTC_T_IDLE = 2'b00,
    GLTC_T_LIN  = 2'b01,
    GLTC_T_EXT  = 2'b10
  } gltc_tstate_t;
  gltc_tstate_t state_reg, state_next;
  logic [19:0] div_reg, div_next;
  logic [7:0]  step_reg, step_next;
  logic        exp_reg;
  wire         step_tick = (div_reg == 20'(STEP_CYC - 1));
  wire         ext_end   = (div_reg == 20'(EXT_CYC - 1));
  wire         lin_end   = step_tick && (step_reg == timeout_code_i - 8'h01);
  wire         fire      = (state_reg == GLTC_T_LIN && lin_end) ||
                           (state_reg == GLTC_T_EXT && ext_end);
  always_comb begin
    state_next = state_reg;
    div_next   = div_reg + 20'h1;
    step_next  = step_reg;
    unique case (state_reg)
      GLTC_T_IDLE: begin
        div_next = 20'h0;
      end
      GLTC_T_LIN: begin
        if (step_tick) begin
          div_next  = 20'h0;
          step_next = step_reg + 8'h01;
        end
      end
      GLTC_T_EXT: ;
      default: state_next = GLTC_T_IDLE;
    endcase
    if (fire || preamble_seen_i)
      state_next = GLTC_T_IDLE;
    if (tx_done_i && timeout_code_i != 8'h00) begin
      div_next   = 20'h0;
      step_next  = 8'h00;
      state_next = (timeout_code_i == `GLTC_TIMEOUT_EXT_CODE) ? GLTC_T_EXT
                                                               : GLTC_T_LIN;
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= GLTC_T_IDLE;
      div_reg   <= 20'h0;
      step_reg  <= 8'h00;
      exp_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg   <= div_next;
      step_reg  <= step_next;
      exp_reg   <= fire && !preamble_seen_i;
    end
  end
  assign running_o = (state_reg != GLTC_T_IDLE);
  assign expired_o = exp_reg;
endmodule

// ---- dv/gltc_config_props.sv ----
`timescale 1ns/10ps
module gltc_config_props #(
  parameter int STEP_CYC = 4,
  parameter int EXT_CYC  = 40
) (
  input wire logic                clock_i,
  input wire logic                arst_n_i,
  input wire gltc_pkg::gltc_req_t req_i,
  input wire logic [1:0]          auto_acknowledge_mode_i,
  input wire logic                tx_done_i,
  input wire logic                preamble_seen_i,
  input wire logic [7:0]          rdata_o,
  input wire logic                rvalid_o,
  input wire gltc_pkg::gltc_cfg_t cfg_o,
  input wire logic                short_preamble_bad_o,
  input wire logic                reply_timer_running_o,
  input wire logic                no_reply_irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  wire       quiet = !tx_done_i && !preamble_seen_i;
  wire [3:0] wd_lo = req_i.wdata[3:0];
  AST_RD_ANSWER: assert property (req_i.re |=> rvalid_o) else $error("no read answer");
  AST_RD_ONLY: assert property (!req_i.re |=> !rvalid_o) else $error("stray answer");
  AST_CAL_LOW: assert property (req_i.we && req_i.addr == 6'h05
    |=> cfg_o.cal_period[7:0] == $past(req_i.wdata)) else $error("cal low lost");
  AST_CAL_HIGH: assert property (req_i.we && req_i.addr == 6'h04
    |=> cfg_o.cal_period[11:8] == $past(wd_lo)) else $error("cal high lost");
  AST_ACK_WAIT: assert property (req_i.we && req_i.addr == 6'h06
    |=> cfg_o.ack_wait_count == $past(req_i.wdata)) else $error("ack wait lost");
  AST_SHORT_BAD: assert property (short_preamble_bad_o ==
    (!cfg_o.preamble_long && cfg_o.rx_coding_sel[2:1] == 2'h0)) else $error("bad flag");
  AST_ARM: assert property (tx_done_i && !preamble_seen_i &&
    cfg_o.reply_timeout_count != 8'h00 |=> reply_timer_running_o) else $error("not armed");
  AST_STOP: assert property (preamble_seen_i && !tx_done_i
    |=> !reply_timer_running_o && !no_reply_irq_o) else $error("timer not stopped");
  AST_ONE_STEP: assert property (STEP_CYC == 4 && tx_done_i && !preamble_seen_i
    && cfg_o.reply_timeout_count == 8'h01 ##1 quiet [*4] |=> no_reply_irq_o)
    else $error("one step timeout wrong");
  AST_IRQ_PULSE: assert property (no_reply_irq_o |=> !no_reply_irq_o) else $error("long irq");
endmodule
bind gltc_config gltc_config_props #(.STEP_CYC(STEP_CYC), .EXT_CYC(EXT_CYC)) u_props (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .req_i(req_i),
  .auto_acknowledge_mode_i(auto_acknowledge_mode_i), .tx_done_i(tx_done_i),
  .preamble_seen_i(preamble_seen_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .cfg_o(cfg_o),
  .short_preamble_bad_o(short_preamble_bad_o),
  .reply_timer_running_o(reply_timer_running_o), .no_reply_irq_o(no_reply_irq_o));

// ---- dv/test_gltc_config.sv ----
`timescale 1ns/10ps
module test_gltc_config;
  localparam int STEP = 4;
  localparam int EXT  = 40;
  typedef struct {logic [5:0] a; logic [7:0] d; logic [7:0] r; logic bad;} gltc_row_t;
  logic                clock_i = 1'b0;
  logic                arst_n_i = 1'b0;
  gltc_pkg::gltc_req_t req_i = '0;
  logic [1:0]          mode_i = 2'h0;
  logic                tx_done_i = 1'b0;
  logic                preamble_seen_i = 1'b0;
  logic [7:0]          rdata_o;
  logic                rvalid_o, bad_o, running_o, irq_o;
  gltc_pkg::gltc_cfg_t cfg_o;
  int                  miscompares = 0;
  int                  comparisons = 0;
  int                  cycles = 0;
  int                  n;
  gltc_row_t rows[10] = '{'{6'h02, 8'hfa, 8'h32, 0}, '{6'h02, 8'h01, 8'h01, 0},
    '{6'h03, 8'h10, 8'h10, 1}, '{6'h03, 8'h93, 8'h93, 0}, '{6'h03, 8'hf1, 8'hf1, 1},
    '{6'h03, 8'hc2, 8'hc2, 0}, '{6'h04, 8'hff, 8'hef, 0}, '{6'h05, 8'ha5, 8'ha5, 0},
    '{6'h06, 8'hff, 8'hff, 0}, '{6'h3f, 8'h55, 8'h00, 0}};
  logic [7:0] rst_val[6] = '{8'h32, 8'hca, 8'h02, 8'h9b, 8'h04, 8'h0f};
  always #25 clock_i = ~clock_i;
  gltc_config #(.STEP_CYC(STEP), .EXT_CYC(EXT)) dut (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .req_i(req_i), .auto_acknowledge_mode_i(mode_i),
    .tx_done_i(tx_done_i), .preamble_seen_i(preamble_seen_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .cfg_o(cfg_o), .short_preamble_bad_o(bad_o),
    .reply_timer_running_o(running_o), .no_reply_irq_o(irq_o));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clock_i);
    req_i = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(negedge clock_i);
    req_i.we = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(negedge clock_i);
    req_i = '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock_i);
    req_i.re = 1'b0;
    chk(12'(rvalid_o), 12'h001);
    chk(12'(rdata_o), 12'(e));
  endtask
  // pulses the end of transmit and counts cycles until the interrupt
  task automatic fire(input logic [7:0] code);
    wr(6'h07, code);
    tx_done_i = 1'b1;
    @(negedge clock_i);
    tx_done_i = 1'b0;
    n = 0;
    while (irq_o !== 1'b1 && n < 2000) begin
      @(negedge clock_i);
      n++;
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(posedge clock_i);
    @(negedge clock_i);
    arst_n_i = 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].r);
      chk(12'(bad_o), 12'(rows[i].bad));
    end
    chk(12'({cfg_o.data_one_len_sel, cfg_o.tari_sel}), 12'h001);
    chk(12'({cfg_o.link_freq_sel, cfg_o.rx_coding_sel}), 12'h062);
    chk(cfg_o.cal_period, 12'hfa5);
    chk(12'({cfg_o.lo_shifter_low_supply, cfg_o.refl_indicator_gain_double,
      cfg_o.refl_indicator_gain_onehalf}), 12'h007);
    for (int v = 0; v < 4; v++) begin
      mode_i = 2'(v);
      @(negedge clock_i);
      chk(12'(cfg_o.auto_acknowledge_mode), 12'(v == 3 ? 2 : v));
    end
    arst_n_i = 1'b0;
    @(negedge clock_i);
    arst_n_i = 1'b1;
    chk(12'({cfg_o.auto_acknowledge_mode, cfg_o.data_one_len_sel}), 12'h003);
    for (int a = 2; a < 8; a++) rd(6'(a), rst_val[a-2]);
    fire(8'h01);
    chk(12'(n), 12'(STEP));
    fire(8'h03);
    chk(12'(n), 12'(3 * STEP));
    @(negedge clock_i);
    chk(12'(irq_o), 12'h000);
    fire(8'hff);
    chk(12'(n), 12'(EXT));
    wr(6'h07, 8'h05);
    tx_done_i = 1'b1;
    @(negedge clock_i);
    tx_done_i = 1'b0;
    repeat (3) @(negedge clock_i);
    preamble_seen_i = 1'b1;
    @(negedge clock_i);
    preamble_seen_i = 1'b0;
    n = 0;
    repeat (30) begin
      @(negedge clock_i);
      n = n + int'(irq_o === 1'b1);
    end
    chk(12'({running_o, n[3:0]}), 12'h000);
    wr(6'h07, 8'h00);
    tx_done_i = 1'b1;
    @(negedge clock_i);
    tx_done_i = 1'b0;
    chk(12'(running_o), 12'h000);
    tally_and_finish();
  end
endmodule
